// File: mdmc_consts.svh
/*
 * constants for the motion detect mode control block: register address,
 * reset value, write mask, field positions and enable-field decode bits.
 * assumes it is included by bare name wherever these macros are used.
 */
`ifndef MDMC_CONSTS_SVH
`define MDMC_CONSTS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define MDMC_CTL_ADDR      8'h27
`define MDMC_CTL_RESET     8'h00
`define MDMC_CTL_WMASK     8'h3f
`define MDMC_RD_UNMAPPED   8'h00

// ****************************************************************
// field decode
// ****************************************************************
`define MDMC_EN_BIT        0
`define MDMC_REF_BIT       1
`define MDMC_SEQ_LINK_BIT  0
`define MDMC_SEQ_AUTO_BIT  1

// ****************************************************************
// counting
// ****************************************************************
`define MDMC_CNT_ZERO      16'h0000
`define MDMC_CNT_ONE       16'h0001

`endif

// File: mdmc_pkg.sv
/*
 * types for the motion detect mode control block.
 * assumes mdmc_consts.svh supplies the numeric constants.
 */
package mdmc_pkg;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] detector_sequencing_mode;
    logic [1:0] stillness_detect_enable;
    logic [1:0] motion_detect_enable;
  } mdmc_ctl_t;

  // armed and referenced flags for one detector
  typedef struct packed {
    logic armed;
    logic referenced;
  } mdmc_det_t;

  typedef enum logic {
    MDMC_ARM_MOTION    = 1'b0,
    MDMC_ARM_STILLNESS = 1'b1
  } mdmc_seq_state_t;

endpackage

// File: mdmc_still_cnt.sv
/*
 * consecutive-sample counter for stillness detection: counts samples in
 * which every axis is below the stillness threshold and pulses once when
 * the programmed count is reached.
 * assumes sample_valid is a one-cycle strobe per output sample.
 */
`timescale 1ns/1ps
`include "mdmc_consts.svh"

module mdmc_still_cnt (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clr,
  input  wire logic        sample_valid,
  input  wire logic        all_below,
  input  wire logic [15:0] stillness_sample_count,
  output logic             done
);

  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        done_ff;
  logic        nxt_done;
  logic [15:0] limit;

  // ****************************************************************
  // counter
  // ****************************************************************
  always_comb begin
    // a zero count behaves as one sample so the detector still fires
    limit    = (stillness_sample_count == `MDMC_CNT_ZERO) ? `MDMC_CNT_ONE : stillness_sample_count;
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (clr) begin
      nxt_cnt = `MDMC_CNT_ZERO;
    end else if (sample_valid) begin
      if (!all_below) begin
        nxt_cnt = `MDMC_CNT_ZERO;
      end else if (cnt_ff < limit) begin
        nxt_cnt  = cnt_ff + `MDMC_CNT_ONE;
        nxt_done = ((cnt_ff + `MDMC_CNT_ONE) == limit);
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff  <= `MDMC_CNT_ZERO;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule

// File: mdmc_ctrl.sv
/*
 * motion detect mode control: control register, enable decode, default /
 * linked / looped sequencing of the motion and stillness detectors, event
 * pending flags and their acknowledge.
 * assumes the serial interface delivers one-cycle register strobes and a
 * one-cycle status_read pulse, and the datapath gives per-sample compares.
 */
`timescale 1ns/1ps
`include "mdmc_consts.svh"

module mdmc_ctrl (
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire logic [7:0]      reg_addr,
  input  wire logic            reg_wr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  input  wire logic            status_read,
  input  wire logic            sample_valid,
  input  wire logic            any_above,
  input  wire logic            all_below,
  input  wire logic [15:0]     stillness_sample_count,
  output mdmc_pkg::mdmc_det_t  motion_det,
  output mdmc_pkg::mdmc_det_t  stillness_det,
  output logic                 temp_adc_act_armed,
  output logic                 motion_pending,
  output logic                 stillness_pending,
  output logic                 autosleep_permit,
  output logic                 seq_active
);

  mdmc_pkg::mdmc_ctl_t       ctl_ff;
  mdmc_pkg::mdmc_ctl_t       nxt_ctl;
  logic [7:0]                rdata_ff;
  logic [7:0]                nxt_rdata;
  mdmc_pkg::mdmc_seq_state_t state_ff;
  mdmc_pkg::mdmc_seq_state_t nxt_state;
  logic                      mot_pend_ff;
  logic                      nxt_mot_pend;
  logic                      stl_pend_ff;
  logic                      nxt_stl_pend;
  logic                      mot_en;
  logic                      stl_en;
  logic                      linked;
  logic                      auto_ack;
  logic                      mot_armed;
  logic                      stl_armed;
  logic                      mot_event;
  logic                      stl_done;
  logic                      stl_event;
  logic                      ack;

  // ****************************************************************
  // control register
  // ****************************************************************
  always_comb begin
    nxt_ctl   = ctl_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr && reg_addr == `MDMC_CTL_ADDR) begin
      nxt_ctl = mdmc_pkg::mdmc_ctl_t'(reg_wdata & `MDMC_CTL_WMASK);
    end
    if (reg_rd) begin
      if (reg_addr == `MDMC_CTL_ADDR) begin
        nxt_rdata = ctl_ff;
      end else begin
        nxt_rdata = `MDMC_RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_ff   <= mdmc_pkg::mdmc_ctl_t'(`MDMC_CTL_RESET);
      rdata_ff <= `MDMC_CTL_RESET;
    end else begin
      ctl_ff   <= nxt_ctl;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // motion and stillness enable decode, link and looped-mode flags
  assign mot_en   = ctl_ff.motion_detect_enable[`MDMC_EN_BIT];
  assign stl_en   = ctl_ff.stillness_detect_enable[`MDMC_EN_BIT];
  assign linked   = ctl_ff.detector_sequencing_mode[`MDMC_SEQ_LINK_BIT] && mot_en && stl_en;
  assign auto_ack = linked && ctl_ff.detector_sequencing_mode[`MDMC_SEQ_AUTO_BIT];

  // concurrent arming, one at a time when linked
  assign mot_armed = mot_en && (!linked || state_ff == mdmc_pkg::MDMC_ARM_MOTION);
  assign stl_armed = stl_en && (!linked || state_ff == mdmc_pkg::MDMC_ARM_STILLNESS);

  assign mot_event = sample_valid && any_above && mot_armed;
  assign stl_event = stl_done && stl_armed;
  // looped mode acknowledges on its own
  assign ack       = status_read || (auto_ack && (mot_pend_ff || stl_pend_ff));

  // ****************************************************************
  // stillness counter
  // ****************************************************************
  // consecutive-sample count
  mdmc_still_cnt u_still_cnt (
    .core_clk               (core_clk),
    .sys_rst                (sys_rst),
    .clr                    (!stl_armed),
    .sample_valid           (sample_valid),
    .all_below              (all_below),
    .stillness_sample_count (stillness_sample_count),
    .done                   (stl_done)
  );

  // ****************************************************************
  // sequencing and pending flags
  // ****************************************************************
  always_comb begin
    nxt_state    = state_ff;
    nxt_mot_pend = mot_pend_ff;
    nxt_stl_pend = stl_pend_ff;
    // pending until acknowledged, a new event beats the clear
    if (ack) begin
      nxt_mot_pend = 1'b0;
      nxt_stl_pend = 1'b0;
    end
    if (mot_event) begin
      nxt_mot_pend = 1'b1;
    end
    if (stl_event) begin
      nxt_stl_pend = 1'b1;
    end
    if (!linked) begin
      // restart a fresh sequence with motion armed
      nxt_state = mdmc_pkg::MDMC_ARM_MOTION;
    end else if (ack) begin
      case (state_ff)
        mdmc_pkg::MDMC_ARM_MOTION: begin
          if (mot_pend_ff) begin
            nxt_state = mdmc_pkg::MDMC_ARM_STILLNESS;
          end
        end
        mdmc_pkg::MDMC_ARM_STILLNESS: begin
          if (stl_pend_ff) begin
            nxt_state = mdmc_pkg::MDMC_ARM_MOTION;
          end
        end
        default: begin
          nxt_state = mdmc_pkg::MDMC_ARM_MOTION;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff    <= mdmc_pkg::MDMC_ARM_MOTION;
      mot_pend_ff <= 1'b0;
      stl_pend_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      mot_pend_ff <= nxt_mot_pend;
      stl_pend_ff <= nxt_stl_pend;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign motion_det.armed         = mot_armed;
  assign motion_det.referenced    = ctl_ff.motion_detect_enable[`MDMC_REF_BIT] && mot_en;
  assign stillness_det.armed      = stl_armed;
  assign stillness_det.referenced = ctl_ff.stillness_detect_enable[`MDMC_REF_BIT] && stl_en;
  assign motion_pending           = mot_pend_ff;
  assign stillness_pending        = stl_pend_ff;
  assign autosleep_permit         = linked;
  // temp/adc activity only in default mode; sequencing does not touch it
  assign temp_adc_act_armed       = mot_en && !linked;
  assign seq_active               = linked;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_rsvd_read_zero: assert property (reg_rd |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved control bits read nonzero");
  a_pend_holds: assert property (motion_pending && !ack |=> motion_pending)
    else $error("motion pending dropped without acknowledge");
  a_event_sets_pend: assert property (mot_event |=> motion_pending)
    else $error("motion event lost");
  a_no_sleep_default: assert property (!(ctl_ff.detector_sequencing_mode[`MDMC_SEQ_LINK_BIT]
                                         && ctl_ff.motion_detect_enable[`MDMC_EN_BIT]
                                         && ctl_ff.stillness_detect_enable[`MDMC_EN_BIT]) |-> !autosleep_permit)
    else $error("autosleep permitted in default mode");
  a_temp_only_default: assert property (temp_adc_act_armed |-> !seq_active)
    else $error("temperature activity armed while sequencing");
  a_one_armed_linked: assert property (seq_active |-> !(motion_det.armed && stillness_det.armed))
    else $error("both detectors armed in linked mode");
  a_auto_ack_clear: assert property (auto_ack && motion_pending && !mot_event && !stl_event
                                     |=> !motion_pending && !stillness_pending)
    else $error("looped mode did not acknowledge internally");
  a_seq_needs_both: assert property (seq_active |-> mot_en && stl_en)
    else $error("sequencing without both enables");
  a_enable_decode: assert property (motion_det.referenced == (ctl_ff.motion_detect_enable == 2'b11))
    else $error("motion enable decode wrong");
  a_still_decode: assert property (stillness_det.referenced |-> ctl_ff.stillness_detect_enable == 2'b11)
    else $error("stillness enable decode wrong");
  a_ack_switches: assert property (seq_active && motion_pending && ack && !reg_wr
                                   && state_ff == mdmc_pkg::MDMC_ARM_MOTION |=> stillness_det.armed)
    else $error("acknowledge did not arm stillness");

  c_linked_switch: cover property (seq_active && motion_pending ##1 stillness_det.armed);
  c_looped_ack: cover property (auto_ack && motion_pending ##1 !motion_pending);
  c_stillness_event: cover property (stl_event);

endmodule

// File: mdmc_host.sv
/*
 * host microcontroller model: writes and reads the control register and
 * reads the status register to acknowledge pending events.
 * assumes one core_clk shared with the device and tasks called from the bench.
 */
`timescale 1ns/1ps

module mdmc_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  output logic            status_read
);
  initial begin
    reg_addr    = 8'h00;
    reg_wr      = 1'b0;
    reg_wdata   = 8'h00;
    reg_rd      = 1'b0;
    status_read = 1'b0;
  end

  // ****************************************
  // register access
  // ****************************************
  // idle bus lines get inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask

  task automatic ack();
    @(posedge core_clk);
    #1;
    status_read = 1'b1;
    @(posedge core_clk);
    #1;
    status_read = 1'b0;
  endtask
endmodule

// File: mdmc_ctrl_bench.sv
/*
 * self-checking bench for mdmc_ctrl: register map, enable decode and the
 * default, linked and looped sequencing of the two detectors.
 * assumes mdmc_host drives the register port and the status read.
 */
`timescale 1ns/1ps

module mdmc_ctrl_bench;
  logic                core_clk = 1'b0;
  logic                sys_rst  = 1'b1;
  logic [7:0]          reg_addr, reg_wdata, reg_rdata;
  logic                reg_wr, reg_rd, status_read;
  logic                sample_valid, any_above, all_below;
  logic [15:0]         stillness_sample_count;
  mdmc_pkg::mdmc_det_t motion_det, stillness_det;
  logic                temp_adc_act_armed, motion_pending, stillness_pending;
  logic                autosleep_permit, seq_active;
  int                  bad_count = 0;
  int                  compares  = 0;
  int                  cycles    = 0;

  always #20 core_clk = ~core_clk;

  mdmc_host mdmc_host_i (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .status_read(status_read));

  mdmc_ctrl mdmc_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_read(status_read),
    .sample_valid(sample_valid), .any_above(any_above), .all_below(all_below),
    .stillness_sample_count(stillness_sample_count), .motion_det(motion_det), .stillness_det(stillness_det),
    .temp_adc_act_armed(temp_adc_act_armed), .motion_pending(motion_pending),
    .stillness_pending(stillness_pending), .autosleep_permit(autosleep_permit), .seq_active(seq_active));

  // ****************************************
  // helpers
  // ****************************************
  task automatic complete_run();
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic sample(input logic above, input logic below);
    @(posedge core_clk);
    #1;
    sample_valid = 1'b1;
    any_above    = above;
    all_below    = below;
    @(posedge core_clk);
    #1;
    sample_valid = 1'b0;
    any_above    = ~above;
    all_below    = ~below;
  endtask

  // three below samples; from a zero count the stillness flag lands one edge after the last
  task automatic still_run();
    repeat (3) sample(1'b0, 1'b1);
    @(posedge core_clk);
    #1;
  endtask

  function automatic logic [7:0] dec(input logic [7:0] v);
    logic sq;
    sq = v[0] & v[2] & v[4];
    return {3'h0, sq, sq, v[0] & ~sq, v[0], v[2] & ~sq};
  endfunction

  function automatic logic [7:0] obs();
    return {3'h0, seq_active, autosleep_permit, temp_adc_act_armed, motion_det.armed, stillness_det.armed};
  endfunction

  // a hang is cut short well past the expected run length
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] v;
    logic [7:0] d;
    void'($urandom(44643));
    stillness_sample_count = 16'h0003;
    sample_valid = 1'b0;
    any_above    = 1'b0;
    all_below    = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    mdmc_host_i.rd(8'h27, d);
    chk(d, 8'h00, "reset value");
    chk(obs(), 8'h00, "reset decode");
    for (int i = 0; i < 64; i++) begin
      v = 8'($urandom());
      v[5:0] = i[5:0];
      mdmc_host_i.wr(8'h27, v);
      mdmc_host_i.rd(8'h27, d);
      chk(d, v & 8'h3f, "readback");
      chk(obs(), dec(v), "decode");
      chk({7'h0, motion_det.referenced}, {7'h0, v[1] & v[0]}, "motion ref");
      chk({7'h0, stillness_det.referenced}, {7'h0, v[3] & v[2]}, "still ref");
    end
    mdmc_host_i.wr(8'h28, 8'hff);
    mdmc_host_i.rd(8'h28, d);
    chk(d, 8'h00, "unmapped read");
    mdmc_host_i.rd(8'h27, d);
    chk(d, v & 8'h3f, "unmapped write");
    for (int k = 1; k >= 0; k--) begin
      mdmc_host_i.wr(8'h27, k ? 8'h25 : 8'h05);
      sample(1'b1, 1'b0);
      chk({7'h0, motion_pending}, 8'h01, "motion event");
      repeat (2) sample(1'b0, 1'b1);
      repeat (2) @(posedge core_clk);
      chk({7'h0, stillness_pending}, 8'h00, "early stillness");
      still_run();
      chk({6'h0, motion_pending, stillness_pending}, 8'h03, "both held");
      mdmc_host_i.ack();
      chk({6'h0, motion_pending, stillness_pending}, 8'h00, "ack clears");
    end
    mdmc_host_i.wr(8'h27, 8'h15);
    sample(1'b1, 1'b0);
    chk({7'h0, motion_pending}, 8'h01, "linked motion");
    mdmc_host_i.ack();
    chk({6'h0, motion_pending, stillness_det.armed}, 8'h01, "linked swap");
    chk({7'h0, motion_det.armed}, 8'h00, "one armed");
    sample(1'b1, 1'b0);
    chk({7'h0, motion_pending}, 8'h00, "dropped event");
    still_run();
    chk({7'h0, stillness_pending}, 8'h01, "linked still");
    mdmc_host_i.ack();
    chk({6'h0, motion_det.armed, stillness_det.armed}, 8'h02, "linked back");
    mdmc_host_i.wr(8'h27, 8'h35);
    sample(1'b1, 1'b0);
    chk({7'h0, motion_pending}, 8'h01, "looped motion");
    @(posedge core_clk);
    #1;
    chk({6'h0, motion_pending, stillness_det.armed}, 8'h01, "looped self ack");
    still_run();
    chk({7'h0, stillness_pending}, 8'h01, "looped still");
    @(posedge core_clk);
    #1;
    chk({6'h0, stillness_pending, motion_det.armed}, 8'h01, "looped back");
    // reset in mid-run with an event pending
    mdmc_host_i.wr(8'h27, 8'h05);
    sample(1'b1, 1'b0);
    sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    chk({7'h0, motion_pending}, 8'h00, "reset clears pending");
    chk(obs(), 8'h00, "mid-run reset decode");
    mdmc_host_i.rd(8'h27, d);
    chk(d, 8'h00, "mid-run reset value");
    complete_run();
  end
endmodule
